// ### core/xlcd_defines.vh
`ifndef XLCD_DEFINES_VH
`define XLCD_DEFINES_VH

// ==========================================================
// Configuration word layout, crystal-loop fields
// ==========================================================
`define XLCD_CFG_W          64
`define XLCD_FINE_BIT       61
`define XLCD_CT_HI          59
`define XLCD_CT_LO          56
`define XLCD_PD_BIT         55
`define XLCD_SWAP_BIT       54
`define XLCD_CP_HI          53
`define XLCD_CP_LO          52
`define XLCD_ROM_HI         51
`define XLCD_ROM_LO         49

// Held field vector: {fine, ct[3:0], pd, swap, cp[1:0], rom[2:0]}
`define XLCD_FLD_W          12
`define XLCD_FLD_RESET      12'h047

// Positions of each field inside the held vector
`define XLCD_F_FINE         11
`define XLCD_F_CT_HI        10
`define XLCD_F_CT_LO        7
`define XLCD_F_PD           6
`define XLCD_F_SWAP         5
`define XLCD_F_CP_HI        4
`define XLCD_F_CP_LO        3
`define XLCD_F_ROM_HI       2
`define XLCD_F_ROM_LO       0

// Reset values of the coarse-tune code and its one-hot select
`define XLCD_CT_RESET       4'h0
`define XLCD_SEL_RESET      16'h0001

// ==========================================================
// Charge-pump current codes and values in nanoamps
// ==========================================================
`define XLCD_CP_W           2
`define XLCD_CUR_W          15
`define XLCD_CP_1U5         2'h0
`define XLCD_CP_5U          2'h1
`define XLCD_CP_8U          2'h2
`define XLCD_CUR_1U5        15'h05dc
`define XLCD_CUR_5U         15'h1388
`define XLCD_CUR_8U         15'h1f40
`define XLCD_CUR_24U        15'h5dc0

// ==========================================================
// Divider ROM codes and VCXO divide ratios
// ==========================================================
`define XLCD_ROM_W          3
`define XLCD_DIV_W          12
`define XLCD_ROM_BYPASS     3'h0
`define XLCD_ROM_24M576     3'h1
`define XLCD_ROM_25M248     3'h2
`define XLCD_ROM_19M44      3'h3
`define XLCD_ROM_20M        3'h4
`define XLCD_ROM_32M        3'h5
`define XLCD_ROM_27M        3'h6
`define XLCD_ROM_OSC_OFF    3'h7
`define XLCD_DIV_1          12'h001
`define XLCD_DIV_3072       12'hc00
`define XLCD_DIV_3156       12'hc54
`define XLCD_DIV_2430       12'h97e
`define XLCD_DIV_2500       12'h9c4
`define XLCD_DIV_4000       12'hfa0
`define XLCD_DIV_3375       12'hd2f
`define XLCD_DIV_NONE       12'h000

// ==========================================================
// Coarse-tune capacitance in hundredths of a picofarad
// ==========================================================
`define XLCD_CT_W           4
`define XLCD_CT_STEPS       16
`define XLCD_CAP_W          12
`define XLCD_CAP_0          12'h3e8
`define XLCD_CAP_1          12'h43c
`define XLCD_CAP_2          12'h491
`define XLCD_CAP_3          12'h4e5
`define XLCD_CAP_4          12'h53a
`define XLCD_CAP_5          12'h58e
`define XLCD_CAP_6          12'h5e2
`define XLCD_CAP_7          12'h637
`define XLCD_CAP_8          12'h68b
`define XLCD_CAP_9          12'h6df
`define XLCD_CAP_10         12'h733
`define XLCD_CAP_11         12'h788
`define XLCD_CAP_12         12'h7dd
`define XLCD_CAP_13         12'h831
`define XLCD_CAP_14         12'h885
`define XLCD_CAP_15         12'h8da

`endif

// ### core/xlcd_cap_decode.v
`include "xlcd_defines.vh"

module xlcd_cap_decode #(
    parameter STEPS = `XLCD_CT_STEPS
) (
    input  wire [`XLCD_CT_W-1:0]  code,
    output reg  [`XLCD_CAP_W-1:0] cap_value,
    output wire [STEPS-1:0]       cap_select
);

    // ======================================================
    // Load capacitance step table
    // ======================================================
    // Value only for reporting; the analog bank uses cap_select
    always @* begin
        case (code)
            4'h0:    cap_value = `XLCD_CAP_0;
            4'h1:    cap_value = `XLCD_CAP_1;
            4'h2:    cap_value = `XLCD_CAP_2;
            4'h3:    cap_value = `XLCD_CAP_3;
            4'h4:    cap_value = `XLCD_CAP_4;
            4'h5:    cap_value = `XLCD_CAP_5;
            4'h6:    cap_value = `XLCD_CAP_6;
            4'h7:    cap_value = `XLCD_CAP_7;
            4'h8:    cap_value = `XLCD_CAP_8;
            4'h9:    cap_value = `XLCD_CAP_9;
            4'ha:    cap_value = `XLCD_CAP_10;
            4'hb:    cap_value = `XLCD_CAP_11;
            4'hc:    cap_value = `XLCD_CAP_12;
            4'hd:    cap_value = `XLCD_CAP_13;
            4'he:    cap_value = `XLCD_CAP_14;
            default: cap_value = `XLCD_CAP_15;
        endcase
    end

    // ======================================================
    // One-hot step select, one line per capacitor step
    // ======================================================
    genvar i;
    generate
        for (i = 0; i < STEPS; i = i + 1) begin : g_step
            assign cap_select[i] = ({{(32-`XLCD_CT_W){1'b0}}, code} == i);
        end
    endgenerate

endmodule

// ### core/xlcd_top.v
// Contract
// - Bits 53:52 pick pump current 1.5, 5, 8 or 24 uA.
// - Bits 51:49 are divider ROM select, also oscillator power-down code.
// - ROM codes 0 to 6 give ratios 1,3072,3156,2430,2500,4000,3375.
// - ROM code 111 powers the oscillator down; no divide ratio applies.
// - Bit 61 set enables fine tuning; clear keeps it inactive.
// - Bit 54 set inverts tune polarity; host picks it per VCXO type.
// - Bits 59:56 pick one of sixteen load capacitance steps, rising.
// - Coarse tuning acts only through the programmable load capacitance.
`include "xlcd_defines.vh"

module xlcd_top #(
    parameter CFG_W = `XLCD_CFG_W
) (
    input  wire                     ref_clk,
    input  wire                     rst,
    input  wire [CFG_W-1:0]         cfg_word,
    input  wire                     cfg_load,
    output reg  [`XLCD_FLD_W-1:0]   xtal_fields_q,
    output reg  [`XLCD_CP_W-1:0]    xtal_loop_pump_current_q,
    output reg  [`XLCD_CUR_W-1:0]   pump_current_na_q,
    output reg  [`XLCD_ROM_W-1:0]   xtal_loop_divider_select_q,
    output reg  [`XLCD_DIV_W-1:0]   vcxo_divide_ratio_q,
    output reg                      divide_ratio_valid_q,
    output reg                      osc_powerdown_q,
    output reg                      xtal_fine_tune_enable_q,
    output reg                      xtal_tune_polarity_swap_q,
    output reg                      xtal_loop_powerdown_q,
    output reg                      xtal_loop_run_q,
    output reg  [`XLCD_CT_W-1:0]    xtal_coarse_tune_code_q,
    output reg  [`XLCD_CAP_W-1:0]   coarse_cap_value_q,
    output reg  [`XLCD_CT_STEPS-1:0] coarse_cap_select_q
);

    // ======================================================
    // Crystal-loop fields picked out of the incoming word
    // ======================================================
    // Bits outside these fields belong to other blocks and
    // are ignored here, whatever the host writes into them.
    wire                   ld_fine;
    wire [`XLCD_CT_W-1:0]  ld_ct;
    wire                   ld_pd;
    wire                   ld_swap;
    wire [`XLCD_CP_W-1:0]  ld_cp;
    wire [`XLCD_ROM_W-1:0] ld_rom;

    assign ld_fine = cfg_word[`XLCD_FINE_BIT];
    assign ld_ct   = cfg_word[`XLCD_CT_HI:`XLCD_CT_LO];
    assign ld_pd   = cfg_word[`XLCD_PD_BIT];
    assign ld_swap = cfg_word[`XLCD_SWAP_BIT];
    assign ld_cp   = cfg_word[`XLCD_CP_HI:`XLCD_CP_LO];
    assign ld_rom  = cfg_word[`XLCD_ROM_HI:`XLCD_ROM_LO];

    // ======================================================
    // Next field vector
    // ======================================================
    // The word comes from the serial front end on this clock,
    // so no synchroniser is needed; a load replaces all fields
    // at once, so a half-written setting never reaches the loop.
    wire [`XLCD_FLD_W-1:0] fields_d;
    wire [`XLCD_FLD_W-1:0] loaded;

    assign loaded = {ld_fine, ld_ct, ld_pd, ld_swap, ld_cp, ld_rom};
    assign fields_d = cfg_load ? loaded : xtal_fields_q;

    // ======================================================
    // Field split of the next value
    // ======================================================
    // Decodes read the next value, not the held one, so a load
    // and its decode land in the same cycle.
    wire                   fine_d;
    wire [`XLCD_CT_W-1:0]  ct_d;
    wire                   pd_d;
    wire                   swap_d;
    wire [`XLCD_CP_W-1:0]  cp_d;
    wire [`XLCD_ROM_W-1:0] rom_d;

    assign fine_d = fields_d[`XLCD_F_FINE];
    assign ct_d   = fields_d[`XLCD_F_CT_HI:`XLCD_F_CT_LO];
    assign pd_d   = fields_d[`XLCD_F_PD];
    assign swap_d = fields_d[`XLCD_F_SWAP];
    assign cp_d   = fields_d[`XLCD_F_CP_HI:`XLCD_F_CP_LO];
    assign rom_d  = fields_d[`XLCD_F_ROM_HI:`XLCD_F_ROM_LO];

    // ======================================================
    // Charge-pump current decode
    // ======================================================
    reg [`XLCD_CUR_W-1:0] cur_d;

    always @* begin
        case (cp_d)
            `XLCD_CP_1U5: cur_d = `XLCD_CUR_1U5;
            `XLCD_CP_5U:  cur_d = `XLCD_CUR_5U;
            `XLCD_CP_8U:  cur_d = `XLCD_CUR_8U;
            default:      cur_d = `XLCD_CUR_24U;
        endcase
    end

    // ======================================================
    // Divider ROM decode
    // ======================================================
    // The all-ones code is a power-down request, not a ratio,
    // so the ratio reads zero and the valid flag drops.
    reg [`XLCD_DIV_W-1:0] div_d;
    wire                  osc_off_d;

    assign osc_off_d = (rom_d == `XLCD_ROM_OSC_OFF);

    always @* begin
        case (rom_d)
            `XLCD_ROM_BYPASS:  div_d = `XLCD_DIV_1;
            `XLCD_ROM_24M576:  div_d = `XLCD_DIV_3072;
            `XLCD_ROM_25M248:  div_d = `XLCD_DIV_3156;
            `XLCD_ROM_19M44:   div_d = `XLCD_DIV_2430;
            `XLCD_ROM_20M:     div_d = `XLCD_DIV_2500;
            `XLCD_ROM_32M:     div_d = `XLCD_DIV_4000;
            `XLCD_ROM_27M:     div_d = `XLCD_DIV_3375;
            default:           div_d = `XLCD_DIV_NONE;
        endcase
    end

    // ======================================================
    // Coarse-tune capacitance decode
    // ======================================================
    // Coarse tuning has no other path than this capacitor bank
    wire [`XLCD_CAP_W-1:0]   cap_d;
    wire [`XLCD_CT_STEPS-1:0] sel_d;

    xlcd_cap_decode #(
        .STEPS      (`XLCD_CT_STEPS)
    ) u_cap (
        .code       (ct_d),
        .cap_value  (cap_d),
        .cap_select (sel_d)
    );

    // ======================================================
    // Held field vector
    // ======================================================
    // Reset leaves the loop and the oscillator powered down, so
    // an unconfigured part draws as little as it can.
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            xtal_fields_q <= `XLCD_FLD_RESET;
        end else begin
            xtal_fields_q <= fields_d;
        end
    end

    // ======================================================
    // Registered charge-pump controls
    // ======================================================
    // All groups below take their next value from fields_d, so
    // fields and decodes move on the same edge and the analog
    // loop never sees a mix of old and new settings.
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            xtal_loop_pump_current_q <= `XLCD_CP_1U5;
            pump_current_na_q        <= `XLCD_CUR_1U5;
        end else begin
            xtal_loop_pump_current_q <= cp_d;
            pump_current_na_q        <= cur_d;
        end
    end

    // ======================================================
    // Registered divider and oscillator controls
    // ======================================================
    // Valid and power-down are two flops rather than one and an
    // inverter, so both stay straight flip-flop outputs.
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            xtal_loop_divider_select_q <= `XLCD_ROM_OSC_OFF;
            vcxo_divide_ratio_q        <= `XLCD_DIV_NONE;
            divide_ratio_valid_q       <= 1'b0;
            osc_powerdown_q            <= 1'b1;
        end else begin
            xtal_loop_divider_select_q <= rom_d;
            vcxo_divide_ratio_q        <= div_d;
            divide_ratio_valid_q       <= ~osc_off_d;
            osc_powerdown_q            <= osc_off_d;
        end
    end

    // ======================================================
    // Registered tune and loop power controls
    // ======================================================
    // Fine tune is not gated by loop power-down; a user who
    // powers the loop down should clear it as well.
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            xtal_fine_tune_enable_q   <= 1'b0;
            xtal_tune_polarity_swap_q <= 1'b0;
            xtal_loop_powerdown_q     <= 1'b1;
            xtal_loop_run_q           <= 1'b0;
        end else begin
            xtal_fine_tune_enable_q   <= fine_d;
            xtal_tune_polarity_swap_q <= swap_d;
            xtal_loop_powerdown_q     <= pd_d;
            xtal_loop_run_q           <= ~pd_d;
        end
    end

    // ======================================================
    // Registered coarse-tune controls
    // ======================================================
    // Code, value and one-hot select share one edge, so the
    // reported value always matches the switched step.
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            xtal_coarse_tune_code_q <= `XLCD_CT_RESET;
            coarse_cap_value_q      <= `XLCD_CAP_0;
            coarse_cap_select_q     <= `XLCD_SEL_RESET;
        end else begin
            xtal_coarse_tune_code_q <= ct_d;
            coarse_cap_value_q      <= cap_d;
            coarse_cap_select_q     <= sel_d;
        end
    end

endmodule

// ### testbench/xlcd_checker.sv
// ==========================================================
// Port-level checks on the crystal-loop decode
// ==========================================================
module xlcd_checker #(
    parameter CFG_W = 64
) (
    input wire logic             ref_clk,
    input wire logic             rst,
    input wire logic [CFG_W-1:0] cfg_word,
    input wire logic             cfg_load,
    input wire logic [11:0]      xtal_fields_q,
    input wire logic [2:0]       xtal_loop_divider_select_q,
    input wire logic [11:0]      vcxo_divide_ratio_q,
    input wire logic             divide_ratio_valid_q,
    input wire logic             osc_powerdown_q,
    input wire logic             xtal_fine_tune_enable_q,
    input wire logic             xtal_tune_polarity_swap_q,
    input wire logic             xtal_loop_powerdown_q,
    input wire logic             xtal_loop_run_q,
    input wire logic [3:0]       xtal_coarse_tune_code_q,
    input wire logic [11:0]      coarse_cap_value_q,
    input wire logic [15:0]      coarse_cap_select_q
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    // Fields follow the word one edge after a load, and only then
    load_fields_a: assert property (cfg_load |=> xtal_fields_q ==
        {$past(cfg_word[61]), $past(cfg_word[59:49])})
        else $error("held fields differ from loaded word");
    hold_fields_a: assert property (!cfg_load |=> $stable(xtal_fields_q))
        else $error("held fields moved without a load");
    fine_tune_a: assert property (cfg_load |=>
        xtal_fine_tune_enable_q == $past(cfg_word[61]))
        else $error("fine tune enable wrong");
    swap_pol_a: assert property (cfg_load |=>
        xtal_tune_polarity_swap_q == $past(cfg_word[54]))
        else $error("polarity swap wrong");
    // Code 7 stops the oscillator and leaves no ratio at all
    osc_off_a: assert property (osc_powerdown_q ==
        (xtal_loop_divider_select_q == 3'h7) && divide_ratio_valid_q ==
        !osc_powerdown_q && (!osc_powerdown_q || vcxo_divide_ratio_q == 12'h000))
        else $error("oscillator power-down decode wrong");
    loop_run_a: assert property (xtal_loop_powerdown_q == xtal_fields_q[6]
        && xtal_loop_run_q == !xtal_loop_powerdown_q)
        else $error("loop power-down decode wrong");
    cap_onehot_a: assert property (coarse_cap_select_q ==
        16'h0001 << xtal_coarse_tune_code_q)
        else $error("capacitor select not one-hot of code");
    cap_rise_a: assert property ((xtal_coarse_tune_code_q >
        $past(xtal_coarse_tune_code_q)) |-> coarse_cap_value_q >
        $past(coarse_cap_value_q))
        else $error("capacitance did not rise with code");
endmodule

// ### testbench/xlcd_host_model.sv
// ==========================================================
// Host side: serial front end handing over a parallel word
// ==========================================================
module xlcd_host_model (
    input  wire logic        req,
    input  wire logic        vcxo_inverse,
    input  wire logic [63:0] word,
    output wire logic        cfg_load,
    output wire logic [63:0] cfg_word
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle word is scrambled so a decode can never lean on it
    assign cfg_load = req;
    assign cfg_word = req ? {word[63:55], vcxo_inverse, word[53:0]}
                          : ~word;
endmodule

// ### testbench/test_crystal_loop_config_decode.sv
module test_crystal_loop_config_decode;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [11:0] RATIO [8] = '{12'h001, 12'hc00, 12'hc54,
        12'h97e, 12'h9c4, 12'hfa0, 12'hd2f, 12'h000};
    localparam logic [11:0] CAP [16] = '{12'h3e8, 12'h43c, 12'h491,
        12'h4e5, 12'h53a, 12'h58e, 12'h5e2, 12'h637, 12'h68b, 12'h6df,
        12'h733, 12'h788, 12'h7dd, 12'h831, 12'h885, 12'h8da};
    localparam logic [14:0] CUR [4] = '{15'h05dc, 15'h1388, 15'h1f40,
        15'h5dc0};
    localparam logic [63:0] RST_WORD = 64'h008e_0000_0000_0000;
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic        req = 1'b0;
    logic        inv = 1'b0;
    logic        chk = 1'b0;
    logic        pend = 1'b0;
    logic [63:0] word = 64'h0;
    logic [63:0] last = 64'h0;
    logic [81:0] exp_q [$];
    logic [81:0] exp;
    integer      fails = 0;
    integer      compares = 0;
    integer      seed = 64;
    integer      cycles = 0;
    wire  [63:0] cfg_word;
    wire         cfg_load;
    wire  [81:0] seen;

    initial forever #2 ref_clk = ~ref_clk;

    xlcd_host_model xlcd_host_model_inst (.req(req), .vcxo_inverse(inv),
        .word(word), .cfg_load(cfg_load), .cfg_word(cfg_word));
    xlcd_top xlcd_top_inst (.ref_clk(ref_clk), .rst(rst),
        .cfg_word(cfg_word), .cfg_load(cfg_load),
        .xtal_fields_q(seen[81:70]), .xtal_loop_pump_current_q(seen[69:68]),
        .pump_current_na_q(seen[67:53]),
        .xtal_loop_divider_select_q(seen[52:50]),
        .vcxo_divide_ratio_q(seen[49:38]), .divide_ratio_valid_q(seen[37]),
        .osc_powerdown_q(seen[36]), .xtal_fine_tune_enable_q(seen[35]),
        .xtal_tune_polarity_swap_q(seen[34]),
        .xtal_loop_powerdown_q(seen[33]), .xtal_loop_run_q(seen[32]),
        .xtal_coarse_tune_code_q(seen[31:28]),
        .coarse_cap_value_q(seen[27:16]), .coarse_cap_select_q(seen[15:0]));

    // Expected decode, laid out in the same order as the output bundle
    function automatic logic [81:0] exp_of(input logic [63:0] w);
        logic [2:0] r;
        r = w[51:49];
        return {w[61], w[59:49], w[53:52], CUR[w[53:52]], r, RATIO[r],
            r != 3'h7, r == 3'h7, w[61], w[54], w[55], !w[55],
            w[59:56], CAP[w[59:56]], 16'h0001 << w[59:56]};
    endfunction

    // Driver notes what each call should produce: a load shows
    // the new word, a quiet cycle must still show the last one
    task automatic send(input logic [63:0] w, input logic ld,
                        input logic iv);
        w[54] = iv;
        @(posedge ref_clk);
        word <= w;
        req <= ld;
        inv <= iv;
        chk <= !ld;
        if (ld)
            last = w;
        exp_q.push_back(exp_of(last));
    endtask

    task automatic test_done;
        if (exp_q.size() != 0)
            fails = fails + 1;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Outputs are settled by the falling edge after the load edge
    always @(posedge ref_clk) pend <= !rst && (cfg_load || chk);
    always @(negedge ref_clk) begin
        if (pend) begin
            compares = compares + 1;
            exp = exp_q.size() ? exp_q.pop_front() : 'x;
            if (seen !== exp) begin
                fails = fails + 1;
                $display("CHECK FAILED decode exp %h seen %h", exp, seen);
            end
        end
    end

    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 1000) begin
            fails = fails + 1;
            test_done;
        end
    end

    // Reset state, every code of every field with loads and holds,
    // then a reset in mid-run and holds after it
    initial begin
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        chk <= 1'b1;
        last = RST_WORD;
        exp_q.push_back(exp_of(last));
        for (int i = 0; i < 64; i++) begin
            logic [63:0] w;
            w = {$random(seed), $random(seed)};
            w[59:56] = i[3:0];
            w[51:49] = i[2:0];
            w[53:52] = i[1:0];
            send(w, i < 24 || w[0], w[1]);
        end
        @(posedge ref_clk);
        req <= 1'b0;
        chk <= 1'b0;
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        chk <= 1'b1;
        last = RST_WORD;
        exp_q.push_back(exp_of(last));
        send(64'h0, 1'b0, 1'b0);
        @(posedge ref_clk);
        chk <= 1'b0;
        repeat (2) @(posedge ref_clk);
        test_done;
    end
endmodule

bind xlcd_top xlcd_checker #(.CFG_W(CFG_W)) xlcd_checker_inst (
    .ref_clk                    (ref_clk),
    .rst                        (rst),
    .cfg_word                   (cfg_word),
    .cfg_load                   (cfg_load),
    .xtal_fields_q              (xtal_fields_q),
    .xtal_loop_divider_select_q (xtal_loop_divider_select_q),
    .vcxo_divide_ratio_q        (vcxo_divide_ratio_q),
    .divide_ratio_valid_q       (divide_ratio_valid_q),
    .osc_powerdown_q            (osc_powerdown_q),
    .xtal_fine_tune_enable_q    (xtal_fine_tune_enable_q),
    .xtal_tune_polarity_swap_q  (xtal_tune_polarity_swap_q),
    .xtal_loop_powerdown_q      (xtal_loop_powerdown_q),
    .xtal_loop_run_q            (xtal_loop_run_q),
    .xtal_coarse_tune_code_q    (xtal_coarse_tune_code_q),
    .coarse_cap_value_q         (coarse_cap_value_q),
    .coarse_cap_select_q        (coarse_cap_select_q)
);
